// ### design/fpg_channel.v
// One pulse generator: fixed prescaler, period divider and width compare.
// Assumes srcTick is a one-cycle pulse on sys_clk from the selected source.
`timescale 1ns/1ps
`include "fpg_map.vh"

module fpg_channel #(
	parameter DIV_W = `FPG_DIV_W,
	parameter WID_W = `FPG_WID_W
) (
	input  wire             sys_clk,
	input  wire             resetn,
	input  wire             srcTick,
	input  wire             enable,
	input  wire [DIV_W-1:0] divisor,
	input  wire [WID_W-1:0] width,
	output reg              pwmOut
);

	reg  [`FPG_PRE_W-1:0]       preCnt_r;
	reg  [DIV_W-1:0]            divCnt_r;
	reg  [DIV_W-1:0]            divSh_r;
	reg  [WID_W-1:0]            widSh_r;
	wire [DIV_W-1:0]            divEff;
	wire                        preWrap;
	wire                        periodWrap;
	wire [DIV_W+WID_W-1:0]      position;
	wire [DIV_W+WID_W-1:0]      highLimit;

	// Zero divisor behaves as one, so the period never collapses
	assign divEff     = (divSh_r == {DIV_W{1'b0}}) ? {{(DIV_W-1){1'b0}}, 1'b1} : divSh_r;
	assign preWrap    = srcTick && (preCnt_r == {`FPG_PRE_W{1'b1}});
	assign periodWrap = preWrap && (divCnt_r == divEff - {{(DIV_W-1){1'b0}}, 1'b1});
	assign position   = {divCnt_r, preCnt_r};
	// high for width/256 of the period
	assign highLimit  = {{DIV_W{1'b0}}, widSh_r} * {{WID_W{1'b0}}, divEff};

	always @(posedge sys_clk) begin
		if (!resetn) begin
			preCnt_r <= {`FPG_PRE_W{1'b0}};
			divCnt_r <= {DIV_W{1'b0}};
			divSh_r  <= `FPG_DIV_RST;
			widSh_r  <= `FPG_WID_RST;
			pwmOut   <= 1'b0;
		end else if (!enable) begin
			// held low, settings follow live values
			preCnt_r <= {`FPG_PRE_W{1'b0}};
			divCnt_r <= {DIV_W{1'b0}};
			divSh_r  <= divisor;
			widSh_r  <= width;
			pwmOut   <= 1'b0;
		end else begin
			pwmOut <= (position < highLimit);
			if (srcTick) begin
				preCnt_r <= preCnt_r + {{(`FPG_PRE_W-1){1'b0}}, 1'b1};
			end
			if (periodWrap) begin
				divCnt_r <= {DIV_W{1'b0}};
				divSh_r  <= divisor;
				widSh_r  <= width;
			end else if (preWrap) begin
				divCnt_r <= divCnt_r + {{(DIV_W-1){1'b0}}, 1'b1};
			end
		end
	end

endmodule // fpg_channel

// ### design/fpg_map.vh
// Address map, field positions and reset values of the fan pulse generator.
// Assumes a 32-bit AHB-Lite data path and one 64 KB window per instance.
`ifndef FPG_MAP_VH
`define FPG_MAP_VH

// Instance windows
`define FPG_WIN_LSB        16
`define FPG_OFF_W          16

// Register byte offsets within one window
`define FPG_OFF_CTRL       16'h0000
`define FPG_OFF_DIVISOR    16'h0004
`define FPG_OFF_WIDTH      16'h0008
`define FPG_OFF_STATUS     16'h000c
`define FPG_OFF_TACH       16'h0010

// Control fields
`define FPG_CTRL_W         5
`define FPG_CTRL_EN        0
`define FPG_CTRL_SRC       1
`define FPG_CTRL_GPIO      2
`define FPG_CTRL_GOUT      3
`define FPG_CTRL_GOE       4
`define FPG_CTRL_RST       5'h00

// Status fields
`define FPG_STAT_PWM       0
`define FPG_STAT_PIN       1

// Field widths and reset values
`define FPG_DIV_W          13
`define FPG_DIV_RST        13'h0001
`define FPG_WID_W          8
`define FPG_WID_RST        8'h00
`define FPG_PRE_W          8
`define FPG_TACH_W         16

// Clocking figures
`define FPG_SYS_CLK_HZ     20000000
`define FPG_OSC_HZ         38400000
`define FPG_OSC_DIV_HZ     19200000
`define FPG_PLL_HZ         408000000
`define FPG_FAN_CLK_MAX_HZ 48000000

`endif

// ### design/fpg_top.v
// Fan pulse generator: AHB-Lite register slave and several pulse instances.
// Assumes source ticks come from sys_clk logic; pins and tach are async.
//
// The register addresses and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`include "fpg_map.vh"

// Summary of operation
// - Each instance drives one pulse output and the instances run independently.
// - Each instance answers in its own 64 KB address window.
// - A 13-bit software divisor sets the output period after the prescaler.
// - An 8-bit width value sets the high part of each period.
// - The source clock first passes a fixed divide-by-256 stage feeding the divider.
// - The source is selectable between the oscillator-derived and the fixed PLL clock.
// - After reset the oscillator-derived source is selected.
// - The fastest source with divisor one gives the highest rate, larger divisors lower it.
// - Each instance holds a programmable divider and a width generator on its output.
// - For fan use the block clock set by the clock controller stays at or below 48 MHz.
// - Each pulse output shares its pin with a general purpose I/O function.
// - A tachometer input per instance counts fan pulses beside the drive.
module fpg_top #(
	parameter NUM_INST = 3,
	parameter IDX_W    = 2,
	parameter DIV_W    = `FPG_DIV_W,
	parameter WID_W    = `FPG_WID_W,
	parameter TACH_W   = `FPG_TACH_W
) (
	input  wire                sys_clk,
	input  wire                resetn,
	input  wire                hsel,
	input  wire [31:0]         haddr,
	input  wire [1:0]          htrans,
	input  wire                hwrite,
	input  wire [2:0]          hsize,
	input  wire [31:0]         hwdata,
	input  wire                hready,
	output reg  [31:0]         hrdata,
	output reg                 hreadyout,
	output reg                 hresp,
	input  wire                crystalOscClockTick,
	input  wire                fixedPllClockTick,
	input  wire [NUM_INST-1:0] pulsePinIn,
	output reg  [NUM_INST-1:0] pulsePinOut,
	output reg  [NUM_INST-1:0] pulsePinOe,
	input  wire [NUM_INST-1:0] tachIn
);

	// Per-instance software state
	reg  [`FPG_CTRL_W-1:0] ctrl_r    [0:NUM_INST-1];
	reg  [DIV_W-1:0]       divisor_r [0:NUM_INST-1];
	reg  [WID_W-1:0]       width_r   [0:NUM_INST-1];
	reg  [TACH_W-1:0]      tach_r    [0:NUM_INST-1];

	// Data-phase state of the bus
	reg                    wrPend_r;
	reg  [IDX_W-1:0]       wrIdx_r;
	reg  [`FPG_OFF_W-1:0]  wrOff_r;

	// Synchronised pin levels
	reg  [NUM_INST-1:0]    pinS1_r;
	reg  [NUM_INST-1:0]    pinS2_r;
	reg  [NUM_INST-1:0]    pinS3_r;
	reg  [NUM_INST-1:0]    pinLvl_r;
	reg  [NUM_INST-1:0]    tachS1_r;
	reg  [NUM_INST-1:0]    tachS2_r;
	reg  [NUM_INST-1:0]    tachS3_r;
	reg  [NUM_INST-1:0]    tachLvl_r;

	wire [NUM_INST-1:0]    pwmLevel;
	wire [NUM_INST-1:0]    tachRise;
	wire                   addrPhase;
	wire [IDX_W-1:0]       aIdx;
	wire [`FPG_OFF_W-1:0]  aOff;
	reg  [31:0]            rdMux;

	assign addrPhase = hsel && hready && htrans[1];
	// window select from the address bits above 64 KB
	assign aIdx      = haddr[`FPG_WIN_LSB+IDX_W-1:`FPG_WIN_LSB];
	assign aOff      = haddr[`FPG_OFF_W-1:0];

	// Bus handshake: zero wait states, always OKAY
	always @(posedge sys_clk) begin
		if (!resetn) begin
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// Address phase capture for writes
	always @(posedge sys_clk) begin
		if (!resetn) begin
			wrPend_r <= 1'b0;
			wrIdx_r  <= {IDX_W{1'b0}};
			wrOff_r  <= {`FPG_OFF_W{1'b0}};
		end else if (hready) begin
			wrPend_r <= addrPhase && hwrite;
			wrIdx_r  <= aIdx;
			wrOff_r  <= aOff;
		end
	end

	// Read mux on the address phase; unmapped offsets read zero
	always @* begin : rdSel
		integer k;
		k     = 0;
		rdMux = 32'h0000_0000;
		for (k = 0; k < NUM_INST; k = k + 1) begin
			if (aIdx == k[IDX_W-1:0]) begin
				case (aOff)
					`FPG_OFF_CTRL: begin
						rdMux[`FPG_CTRL_W-1:0] = ctrl_r[k];
					end
					`FPG_OFF_DIVISOR: begin
						rdMux[DIV_W-1:0] = divisor_r[k];
					end
					`FPG_OFF_WIDTH: begin
						rdMux[WID_W-1:0] = width_r[k];
					end
					`FPG_OFF_STATUS: begin
						rdMux[`FPG_STAT_PWM] = pwmLevel[k];
						rdMux[`FPG_STAT_PIN] = pinLvl_r[k];
					end
					`FPG_OFF_TACH: begin
						rdMux[TACH_W-1:0] = tach_r[k];
					end
					default: begin
						rdMux = 32'h0000_0000;
					end
				endcase
			end
		end
	end

	// Read data registered so it stands through the data phase
	always @(posedge sys_clk) begin
		if (!resetn) begin
			hrdata <= 32'h0000_0000;
		end else if (addrPhase && !hwrite) begin
			hrdata <= rdMux;
		end
	end

	// Three-stage sampling of asynchronous pins
	always @(posedge sys_clk) begin
		if (!resetn) begin
			pinS1_r   <= {NUM_INST{1'b0}};
			pinS2_r   <= {NUM_INST{1'b0}};
			pinS3_r   <= {NUM_INST{1'b0}};
			tachS1_r  <= {NUM_INST{1'b0}};
			tachS2_r  <= {NUM_INST{1'b0}};
			tachS3_r  <= {NUM_INST{1'b0}};
		end else begin
			pinS1_r   <= pulsePinIn;
			pinS2_r   <= pinS1_r;
			pinS3_r   <= pinS2_r;
			tachS1_r  <= tachIn;
			tachS2_r  <= tachS1_r;
			tachS3_r  <= tachS2_r;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_INST; g = g + 1) begin : inst
			localparam [IDX_W-1:0] INST_IDX = g;
			wire                   writeHere;
			wire                   srcTick;

			assign writeHere = wrPend_r && (wrIdx_r == INST_IDX);

			// A level change counts only once stages two and three agree
			always @(posedge sys_clk) begin
				if (!resetn) begin
					pinLvl_r[g]  <= 1'b0;
					tachLvl_r[g] <= 1'b0;
				end else begin
					if (pinS2_r[g] == pinS3_r[g]) begin
						pinLvl_r[g] <= pinS3_r[g];
					end
					if (tachS2_r[g] == tachS3_r[g]) begin
						tachLvl_r[g] <= tachS3_r[g];
					end
				end
			end

			assign tachRise[g] = (tachS2_r[g] == tachS3_r[g]) && tachS3_r[g] && !tachLvl_r[g];

			// Software registers of this window
			always @(posedge sys_clk) begin
				if (!resetn) begin
					ctrl_r[g]    <= `FPG_CTRL_RST;
					divisor_r[g] <= `FPG_DIV_RST;
					width_r[g]   <= `FPG_WID_RST;
				end else if (writeHere) begin
					case (wrOff_r)
						`FPG_OFF_CTRL: begin
							ctrl_r[g] <= hwdata[`FPG_CTRL_W-1:0];
						end
						`FPG_OFF_DIVISOR: begin
							divisor_r[g] <= hwdata[DIV_W-1:0];
						end
						`FPG_OFF_WIDTH: begin
							width_r[g] <= hwdata[WID_W-1:0];
						end
						default: begin
							ctrl_r[g] <= ctrl_r[g];
						end
					endcase
				end
			end

			// tach edge count; a clearing write restarts the count at one if an edge comes in the same cycle
			always @(posedge sys_clk) begin
				if (!resetn) begin
					tach_r[g] <= {TACH_W{1'b0}};
				end else if (writeHere && (wrOff_r == `FPG_OFF_TACH)) begin
					tach_r[g] <= {{(TACH_W-1){1'b0}}, tachRise[g]};
				end else if (tachRise[g]) begin
					tach_r[g] <= tach_r[g] + {{(TACH_W-1){1'b0}}, 1'b1};
				end
			end

			// source select between oscillator and PLL ticks
			// tick rate stays within the fan clock limit
			assign srcTick = ctrl_r[g][`FPG_CTRL_SRC] ? fixedPllClockTick
			                                         : crystalOscClockTick;

			// rate falls as the divisor grows
			fpg_channel #(
				.DIV_W (DIV_W),
				.WID_W (WID_W)
			) u_chan (
				.sys_clk (sys_clk),
				.resetn  (resetn),
				.srcTick (srcTick),
				.enable  (ctrl_r[g][`FPG_CTRL_EN]),
				.divisor (divisor_r[g]),
				.width   (width_r[g]),
				.pwmOut  (pwmLevel[g])
			);

			// pin shared with general purpose I/O
			always @(posedge sys_clk) begin
				if (!resetn) begin
					pulsePinOut[g] <= 1'b0;
					pulsePinOe[g]  <= 1'b0;
				end else if (ctrl_r[g][`FPG_CTRL_GPIO]) begin
					pulsePinOut[g] <= ctrl_r[g][`FPG_CTRL_GOUT];
					pulsePinOe[g]  <= ctrl_r[g][`FPG_CTRL_GOE];
				end else begin
					// Pulse mode drives always, so the load sees a firm low when idle
					pulsePinOut[g] <= pwmLevel[g];
					pulsePinOe[g]  <= 1'b1;
				end
			end
		end
	endgenerate

endmodule // fpg_top

// ### testbench/fpg_fan_model.sv
// Fan load on the pulse pins, with a tacho that follows the drive.
// Assumes pins carry no pull; an undriven pin wanders every cycle.
`timescale 1ns/1ps
module fpg_fan_model #(
	parameter N = 3
) (
	input  wire logic         sys_clk,
	input  wire logic [N-1:0] pinOut,
	input  wire logic [N-1:0] pinOe,
	output wire logic [N-1:0] pinLevel,
	output logic      [N-1:0] tachPulse
);
	logic [N-1:0] floatPat = '0;
	always @(posedge sys_clk) begin
		floatPat <= ~floatPat;
	end
	assign pinLevel = (pinOe & pinOut) | (~pinOe & floatPat);
	always @(posedge sys_clk) begin
		tachPulse <= pinLevel & pinOe;
	end
endmodule // fpg_fan_model

// ### testbench/fpg_top_assertions.sv
// Port checker for the fan pulse generator top module.
// Assumes the bus hready is tied to hreadyout and one clock domain.
`timescale 1ns/1ps
module fpg_top_chk #(
	parameter NUM_INST = 3
) (
	input wire logic                sys_clk,
	input wire logic                resetn,
	input wire logic                hsel,
	input wire logic [31:0]         haddr,
	input wire logic [1:0]          htrans,
	input wire logic                hwrite,
	input wire logic [31:0]         hrdata,
	input wire logic                hreadyout,
	input wire logic                hresp,
	input wire logic                crystalOscClockTick,
	input wire logic                fixedPllClockTick,
	input wire logic [NUM_INST-1:0] pulsePinOut,
	input wire logic [NUM_INST-1:0] pulsePinOe
);
	wire rdTake = hsel && hreadyout && htrans[1] && !hwrite;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// No tick and no transfer: nothing may move the pin
	sequence quiet;
		!(crystalOscClockTick || fixedPllClockTick || (hsel && htrans[1]))[*6];
	endsequence
	okay_resp_a: assert property (!hresp)
		else $error("response not OKAY");
	ready_up_a: assert property ($past(resetn) |-> hreadyout)
		else $error("slave stalled after reset");
	reset_idle_a: assert property (disable iff (1'b0)
		!resetn |=> !hreadyout && pulsePinOut == 0 && pulsePinOe == 0)
		else $error("outputs active in reset");
	bad_window_a: assert property (rdTake && haddr[17:16] >= NUM_INST |=> hrdata == 0)
		else $error("absent window read nonzero");
	unmapped_rd_a: assert property (rdTake && haddr[15:0] > 16'h0010 |=> hrdata == 0)
		else $error("unmapped offset read nonzero");
	div_width_a: assert property (rdTake && haddr[15:0] == 16'h0004 |=> hrdata[31:13] == 0)
		else $error("divisor wider than 13 bits");
	rdata_hold_a: assert property (!rdTake |=> $stable(hrdata))
		else $error("read data moved without a read");
	pin_quiet_a: assert property (quiet |-> $stable(pulsePinOut))
		else $error("pin moved without a source tick");
endmodule // fpg_top_chk
bind fpg_top fpg_top_chk #(.NUM_INST(NUM_INST)) i_chk (.sys_clk(sys_clk), .resetn(resetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .crystalOscClockTick(crystalOscClockTick),
	.fixedPllClockTick(fixedPllClockTick), .pulsePinOut(pulsePinOut), .pulsePinOe(pulsePinOe));

// ### testbench/tb_top.sv
// Self-checking bench: AHB-Lite master tasks and a fan load around fpg_top.
// Assumes 50 ns clock; oscillator ticks every second cycle, PLL every cycle.
`timescale 1ns/1ps
module tb_top;
	logic        sys_clk, resetn, hsel, hwrite, oscTick, pllTick;
	logic [31:0] haddr, hwdata, hrdata, rv, b;
	logic [1:0]  htrans;
	logic [2:0]  hsize, pinIn, pinOut, pinOe, tachIn, oth, lvl;
	logic        hreadyout, hresp, s, tickRun;
	int          errors, n_checks, cyc, hi, d, w, per;

	fpg_top i_dut (.sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .crystalOscClockTick(oscTick),
		.fixedPllClockTick(pllTick), .pulsePinIn(pinIn), .pulsePinOut(pinOut),
		.pulsePinOe(pinOe), .tachIn(tachIn));
	fpg_fan_model i_fan (.sys_clk(sys_clk), .pinOut(pinOut), .pinOe(pinOe), .pinLevel(pinIn),
		.tachPulse(tachIn));

	initial begin
		sys_clk = 0;
		forever #25 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		oscTick <= tickRun && !oscTick;
		pllTick <= tickRun;
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			errors++;
			close_out();
		end
	end

	task close_out;
		if (errors == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input logic [31:0] seen, exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Address phase held until hready, then data phase until hready
	task xfer(input logic [31:0] a, dat, input logic wr);
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= wr;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= dat;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		rv = hrdata;
	endtask
	// Idle cycle first so a preceding write has landed
	task rdc(input logic [31:0] a, exp, input string what);
		@(posedge sys_clk);
		xfer(a, 0, 0);
		chk(rv, exp, what);
	endtask

	initial begin
		resetn = 0;
		hsel = 1;
		htrans = 0;
		haddr = 0;
		hwrite = 0;
		hsize = 3'b010;
		hwdata = 0;
		oscTick = 0;
		pllTick = 1;
		tickRun = 1;
		repeat (12) @(posedge sys_clk);
		resetn <= 1;
		repeat (2) @(posedge sys_clk);
		for (int i = 0; i < 3; i++) begin
			b = i << 16;
			rdc(b, 0, "ctrl");
			rdc(b + 4, 1, "divisor");
			rdc(b + 8, 0, "width");
			rdc(b + 16, 0, "tach");
			rdc(b + 20, 0, "unmapped");
			xfer(b + 4, 32'hffff_ffff, 1);
			xfer(b + 8, 32'hffff_ffff, 1);
			xfer(b + 12, 32'hffff_ffff, 1);
			rdc(b + 4, 32'h1fff, "divisor max");
			rdc(b + 8, 32'hff, "width max");
			rdc(b + 12, 0, "status");
		end
		rdc(32'h0003_0004, 0, "absent window");
		for (int i = 0; i < 3; i++) begin
			b = i << 16;
			d = i + 1;
			w = (i == 0) ? 64 : (i == 1) ? 255 : 1;
			s = ~i[0];
			per = 256 * d * (s ? 1 : 2);
			xfer(b + 4, d, 1);
			xfer(b + 8, w, 1);
			xfer(b, 1 | s << 1, 1);
			repeat (per + 8) @(posedge sys_clk);
			xfer(b + 16, 0, 1);
			hi = 0;
			oth = 0;
			repeat (per) begin
				@(posedge sys_clk);
				hi += pinOut[i];
				oth |= pinOut & ~(3'b1 << i);
			end
			chk(hi, w * d * (s ? 1 : 2), "high cycles");
			chk(oth, 0, "other pins");
			@(posedge sys_clk);
			xfer(b + 16, 0, 0);
			chk(rv == 1 || rv == 2, 1, "tach count");
			chk(rv >> 16, 0, "tach upper bits");
			// Ticks held off: the pin must freeze once the pipeline drains
			tickRun <= 1'b0;
			repeat (4) @(posedge sys_clk);
			lvl = pinOut;
			repeat (8) @(posedge sys_clk);
			chk(pinOut, lvl, "pin frozen");
			tickRun <= 1'b1;
			xfer(b, 0, 1);
			repeat (4) @(posedge sys_clk);
			chk(pinOut[i], 0, "disabled pin");
		end
		xfer(0, 32'h1c, 1);
		// Pin level needs the three sampling stages before status shows it
		repeat (5) @(posedge sys_clk);
		chk({pinOut[0], pinOe[0]}, 2'b11, "gpio drive");
		rdc(12, 2, "pin status");
		xfer(0, 32'h04, 1);
		repeat (3) @(posedge sys_clk);
		chk(pinOe[0], 0, "gpio release");
		close_out();
	end
endmodule // tb_top
